//--- acso_pkg.sv
// shared constants and types for the conversion-cycle serial output link
package acso_pkg;
  localparam int WORD_BITS = 32;
  localparam int RESULT_BITS = 24;
  localparam int SUB_BITS = 5;
  localparam int CNT_W = 6;
  // conversion length in system clocks (internal oscillator, per notch)
  localparam int CONV_CYC_50 = 4096;
  localparam int CONV_CYC_60 = 3413;
  // external frequency clock: conversion spans a fixed edge count
  localparam int EXT_OSC_EDGES = 2560;
  localparam int CAL_CYC = 16;
  // internal serial clock half period in system clocks
  localparam int ISCK_HALF = 8;
  // edges seen on the frequency pin inside this window mean a clock
  localparam int F_WIN = 1024;
  localparam logic [5:0] BITS_LAST = 6'h20;
  localparam logic DUMMY_VAL = 1'b0;
  typedef enum logic [2:0] {
    ST_CONV = 3'h1,
    ST_SLEEP = 3'h2,
    ST_OUT = 3'h4
  } acso_state_e;
endpackage

//--- acso_if.sv
// pins between converter and host
`timescale 1ns/100ps
`default_nettype none
interface acso_if;
  logic csN;
  logic sdoOut;
  logic sdoOe;
  logic sckDevOut;
  logic sckDevOe;
  logic sckPullUp;
  logic sckHostOut;
  logic sckHostOe;
  logic notchFreqCtl;
  logic sckWire;
  logic sdoWire;
  // resolve the wires from the enables; pull-up keeps clock high
  assign sckWire = sckDevOe ? sckDevOut :
                   (sckHostOe ? sckHostOut : 1'b1);
  assign sdoWire = sdoOe ? sdoOut : 1'b1;
  modport device (
    input csN, sckWire, notchFreqCtl,
    output sdoOut, sdoOe, sckDevOut, sckDevOe, sckPullUp
  );
  modport host (
    input sdoWire, sckWire,
    output csN, sckHostOut, sckHostOe, notchFreqCtl
  );
endinterface
`default_nettype wire

//--- acso_device.sv
// converter end: cycle sequencer and serial output shift register
`timescale 1ns/100ps
`default_nettype none
module acso_device
  import acso_pkg::*;
#(
  parameter int CONV50 = CONV_CYC_50,
  parameter int CONV60 = CONV_CYC_60
) (
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // link pins
  acso_if.device lnk,
  // result source from the modulator side
  input wire logic [RESULT_BITS-1:0] resultIn,
  input wire logic signIn,
  input wire logic [SUB_BITS-1:0] subIn,
  // status
  output logic convBusy,
  output logic extMode,
  output logic calActive,
  output logic notch50,
  output logic extSysClk
);
  // three-stage synchronisers for pins
  logic [2:0] csSy_ff, sckSy_ff, fSy_ff;
  logic csN, sckIn, fIn, csPrev_ff, sckPrev_ff, fPrev_ff;
  acso_state_e state_ff;
  logic [WORD_BITS-1:0] shReg_ff;
  logic [CNT_W-1:0] bitCnt_ff;
  logic [15:0] convCnt_ff;
  logic [15:0] isckCnt_ff;
  logic isck_ff;
  logic extSck_ff;
  logic [10:0] fWin_ff;
  logic fSeen_ff, fTwo_ff, extF_ff;
  logic [2:0] porCnt_ff; // cycles since reset release, saturating
  logic porCap; // one-cycle power-up mode sample
  logic sdo_ff;
  logic csFall, csRise, sckFall, fEdge, isckFall, shiftEv, convDone;
  logic [15:0] convLen;

  // synchronise pins; value counts when stages two and three agree
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      csSy_ff <= 3'h7;
      sckSy_ff <= 3'h7;
      fSy_ff <= 3'h0;
    end else begin
      csSy_ff <= {csSy_ff[1:0], lnk.csN};
      sckSy_ff <= {sckSy_ff[1:0], lnk.sckWire};
      fSy_ff <= {fSy_ff[1:0], lnk.notchFreqCtl};
    end
  end
  // filtered levels held until stages agree
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      csPrev_ff <= 1'b1;
      sckPrev_ff <= 1'b1;
      fPrev_ff <= 1'b0;
    end else begin
      csPrev_ff <= csN;
      sckPrev_ff <= sckIn;
      fPrev_ff <= fIn;
    end
  end
  assign csN = (csSy_ff[1] == csSy_ff[2]) ? csSy_ff[2] : csPrev_ff;
  assign sckIn = (sckSy_ff[1] == sckSy_ff[2]) ? sckSy_ff[2] : sckPrev_ff;
  assign fIn = (fSy_ff[1] == fSy_ff[2]) ? fSy_ff[2] : fPrev_ff;
  assign csFall = csPrev_ff & ~csN;
  assign csRise = ~csPrev_ff & csN;
  assign sckFall = sckPrev_ff & ~sckIn;
  assign fEdge = fPrev_ff & ~fIn;

  // frequency pin: edges within window mean external system clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fWin_ff <= '0;
      fSeen_ff <= 1'b0;
      fTwo_ff <= 1'b0;
      extF_ff <= 1'b0;
    end else if (fWin_ff == 11'(F_WIN - 1)) begin
      fWin_ff <= '0;
      // one level change is a re-tied pin; two falls mean a clock
      extF_ff <= fTwo_ff | (fSeen_ff & fEdge);
      fSeen_ff <= 1'b0;
      fTwo_ff <= 1'b0;
    end else begin
      fWin_ff <= fWin_ff + 11'h1;
      fSeen_ff <= fSeen_ff | fEdge;
      fTwo_ff <= fTwo_ff | (fSeen_ff & fEdge);
    end
  end
  assign extSysClk = extF_ff;
  assign notch50 = fIn;

  // power-up sample waits until the pin synchronisers hold the pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      porCnt_ff <= '0;
    end else if (porCnt_ff != '1) begin
      porCnt_ff <= porCnt_ff + 3'h1;
    end
  end
  assign porCap = (porCnt_ff == 3'h4);

  // serial clock mode caught once after reset and on every select fall
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      extSck_ff <= 1'b0;
    end else if (csFall || porCap) begin
      extSck_ff <= ~sckIn;
    end
  end
  assign extMode = extSck_ff;

  // conversion length: internal notch choice or external edge count
  always_comb begin
    if (extF_ff) begin
      convLen = 16'(EXT_OSC_EDGES);
    end else if (fIn) begin
      convLen = 16'(CONV50);
    end else begin
      convLen = 16'(CONV60);
    end
  end

  // conversion timer; advances on frequency edges when clocked externally
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      convCnt_ff <= '0;
    end else if (state_ff != ST_CONV) begin
      convCnt_ff <= '0;
    end else if (!extF_ff || fEdge) begin
      convCnt_ff <= convCnt_ff + 16'h1;
    end
  end
  assign convDone = (state_ff == ST_CONV) && (convCnt_ff >= convLen);
  // full-scale calibration folded into the tail of each conversion
  assign calActive = (state_ff == ST_CONV) &&
                     (convCnt_ff + 16'(CAL_CYC) >= convLen);

  // internal serial clock divider, runs only in output state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      isckCnt_ff <= '0;
      isck_ff <= 1'b0;
    end else if (state_ff != ST_OUT || extSck_ff) begin
      // parked low: entering output pulls the pin down with no shift
      isckCnt_ff <= '0;
      isck_ff <= 1'b0;
    end else if (isckCnt_ff == 16'(ISCK_HALF - 1)) begin
      isckCnt_ff <= '0;
      isck_ff <= ~isck_ff;
    end else begin
      isckCnt_ff <= isckCnt_ff + 16'h1;
    end
  end
  assign isckFall = isck_ff && isckCnt_ff == 16'(ISCK_HALF - 1);
  assign shiftEv = extSck_ff ? sckFall : isckFall;

  // state machine
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_CONV;
    end else begin
      unique case (state_ff)
        ST_CONV: if (convDone) state_ff <= ST_SLEEP;
        ST_SLEEP: if (!csN) state_ff <= ST_OUT;
        ST_OUT: begin
          if (csRise) begin
            state_ff <= ST_CONV;
          end else if (shiftEv && bitCnt_ff == BITS_LAST - 6'h1) begin
            state_ff <= ST_CONV;
          end
        end
        default: state_ff <= ST_CONV;
      endcase
    end
  end
  assign convBusy = (state_ff == ST_CONV);

  // shift register: load new word at conversion end, shift on falls
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shReg_ff <= '0;
      bitCnt_ff <= '0;
    end else if (convDone) begin
      // done flag, dummy, sign, result, sub bits
      shReg_ff <= {1'b0, DUMMY_VAL, signIn, resultIn, subIn};
      bitCnt_ff <= '0;
    end else if (state_ff == ST_OUT && shiftEv) begin
      shReg_ff <= {shReg_ff[WORD_BITS-2:0], 1'b1};
      bitCnt_ff <= bitCnt_ff + 6'h1;
    end
  end

  // serial output data: busy flag during conversion, else word msb
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdo_ff <= 1'b1;
    end else if (state_ff == ST_CONV && !convDone) begin
      sdo_ff <= 1'b1;
    end else if (convDone) begin
      sdo_ff <= 1'b0;
    end else if (state_ff == ST_OUT && shiftEv) begin
      sdo_ff <= (bitCnt_ff == BITS_LAST - 6'h1) ? 1'b1 :
                shReg_ff[WORD_BITS-2];
    end
  end
  assign lnk.sdoOut = sdo_ff;
  assign lnk.sdoOe = ~csN;
  assign lnk.sckDevOut = isck_ff;
  assign lnk.sckDevOe = ~extSck_ff && state_ff == ST_OUT;
  assign lnk.sckPullUp = ~extSck_ff;
endmodule
`default_nettype wire

//--- acso_host.sv
// host end: selects the converter, clocks or receives the 32-bit word
`timescale 1ns/100ps
`default_nettype none
module acso_host
  import acso_pkg::*;
#(
  parameter int HALF = 8
) (
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // link pins
  acso_if.host lnk,
  // user side
  input wire logic readReq,
  input wire logic useExtSck,
  input wire logic abortReq,
  input wire logic freqSel,
  output logic readBusy,
  output logic wordValid,
  output logic [WORD_BITS-1:0] wordData
);
  logic [2:0] sdoSy_ff, sckSy_ff;
  logic sckPrev_ff, sdoPrev_ff, sdoIn, sckIn, active_ff, cs_ff, sck_ff;
  logic [15:0] div_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [WORD_BITS-1:0] sh_ff;
  logic valid_ff, rise;

  // synchronisers for device-driven pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdoSy_ff <= 3'h7;
      sckSy_ff <= 3'h7;
      sckPrev_ff <= 1'b1;
      sdoPrev_ff <= 1'b1;
    end else begin
      sdoSy_ff <= {sdoSy_ff[1:0], lnk.sdoWire};
      sckSy_ff <= {sckSy_ff[1:0], lnk.sckWire};
      sckPrev_ff <= sckIn;
      sdoPrev_ff <= sdoIn;
    end
  end
  assign sdoIn = (sdoSy_ff[1] == sdoSy_ff[2]) ? sdoSy_ff[2] : sdoPrev_ff;
  assign sckIn = (sckSy_ff[1] == sckSy_ff[2]) ? sckSy_ff[2] : sckPrev_ff;
  assign rise = ~sckPrev_ff & sckIn;

  // transfer control; own clock in external mode after done flag low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_ff <= 1'b0;
      cs_ff <= 1'b1;
      sck_ff <= 1'b1;
      div_ff <= '0;
      cnt_ff <= '0;
      sh_ff <= '0;
      valid_ff <= 1'b0;
      wordData <= '0;
    end else begin
      valid_ff <= 1'b0;
      if (!active_ff) begin
        if (readReq) begin
          active_ff <= 1'b1;
          cs_ff <= 1'b0;
          cnt_ff <= '0;
          div_ff <= '0;
          sck_ff <= ~useExtSck;
        end
      end else if (abortReq) begin
        active_ff <= 1'b0;
        cs_ff <= 1'b1;
      end else if (cnt_ff == BITS_LAST) begin
        active_ff <= 1'b0;
        cs_ff <= 1'b1;
        valid_ff <= 1'b1;
        wordData <= sh_ff;
      end else begin
        if (useExtSck && (cnt_ff != 6'h0 || !sdoIn)) begin
          if (div_ff == 16'(HALF - 1)) begin
            div_ff <= '0;
            sck_ff <= ~sck_ff;
          end else begin
            div_ff <= div_ff + 16'h1;
          end
        end
        if (rise) begin
          sh_ff <= {sh_ff[WORD_BITS-2:0], sdoIn};
          cnt_ff <= cnt_ff + 6'h1;
        end
      end
    end
  end
  assign lnk.csN = cs_ff;
  assign lnk.sckHostOut = sck_ff;
  assign lnk.sckHostOe = useExtSck;
  assign lnk.notchFreqCtl = freqSel;
  assign readBusy = active_ff;
  assign wordValid = valid_ff;
endmodule
`default_nettype wire

//--- acso_props.sv
// assertions on the converter-host link pins
`timescale 1ns/100ps
`default_nettype none
module acso_props
  import acso_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // link pins
  input wire logic csN,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic sckDevOe,
  input wire logic sckPullUp,
  input wire logic sckHostOe,
  input wire logic sckWire
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [5:0] rises_ff; // clock rises seen in this select
  // count clock rises while selected, cleared when deselected
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rises_ff <= 6'h00;
    else if (csN) rises_ff <= 6'h00;
    else if ($rose(sckWire)) rises_ff <= rises_ff + 6'h01;
  end
  a_sdo_float: assert property (csN [*8] |-> !sdoOe)
    else $error("serial out driven while deselected");
  a_sdo_wake: assert property ($fell(csN) |-> ##[1:8] sdoOe)
    else $error("serial out not enabled after select");
  a_pull_internal: assert property (sckDevOe |-> sckPullUp)
    else $error("clock driven without pull-up");
  a_clk_single: assert property (!(sckDevOe && sckHostOe))
    else $error("both ends drive the clock");
  a_devclk_idle: assert property (csN [*8] |-> !sckDevOe)
    else $error("device drives clock while deselected");
  a_sdo_on_fall: assert property ($rose(sckWire) && sdoOe |->
    $stable(sdoOut) ##1 $stable(sdoOut))
    else $error("serial out moved at a clock rise");
  a_bits_capped: assert property (!csN |-> rises_ff <= BITS_LAST)
    else $error("more than 32 clocks in one word");
  a_done_first: assert property ($rose(sckWire) && !csN &&
    rises_ff == 6'h00 |-> !sdoOut)
    else $error("first bit is not a low done flag");
  a_dummy_second: assert property ($rose(sckWire) &&
    rises_ff == 6'h01 |-> sdoOut == DUMMY_VAL)
    else $error("second bit is not the dummy");
  // main scenarios: full word, cut-short word, host-clocked read
  c_full_word: cover property (!csN && rises_ff == BITS_LAST);
  c_abort: cover property ($rose(csN) && rises_ff == 6'h09);
  c_ext_read: cover property (!csN && sckHostOe && $rose(sckWire));
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench: converter and host ends joined
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_top;
  import acso_pkg::*;
  logic clk_sys = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic readReq = 1'b0; // user side of the host
  logic useExtSck = 1'b0;
  logic abortReq = 1'b0;
  logic freqSel = 1'b1;
  logic [RESULT_BITS-1:0] resultIn = '0; // modulator result
  logic signIn = 1'b0;
  logic [SUB_BITS-1:0] subIn = '0;
  logic convBusy, extMode, calActive, notch50, extSysClk, readBusy, wordValid;
  logic [WORD_BITS-1:0] wordData;
  logic [WORD_BITS-1:0] expWord; // word the bench expects
  int seed = 70012;
  int miscompares = 0;
  int compares = 0;
  acso_if u_acso_if ();
  acso_device #(.CONV50(64), .CONV60(50)) u_acso_device (
    .clk_sys(clk_sys), .nrst(nrst), .lnk(u_acso_if),
    .resultIn(resultIn), .signIn(signIn), .subIn(subIn),
    .convBusy(convBusy), .extMode(extMode), .calActive(calActive),
    .notch50(notch50), .extSysClk(extSysClk));
  acso_host #(.HALF(8)) u_acso_host (
    .clk_sys(clk_sys), .nrst(nrst), .lnk(u_acso_if),
    .readReq(readReq), .useExtSck(useExtSck), .abortReq(abortReq),
    .freqSel(freqSel), .readBusy(readBusy), .wordValid(wordValid),
    .wordData(wordData));
  acso_props u_acso_props (
    .clk_sys(clk_sys), .nrst(nrst), .csN(u_acso_if.csN),
    .sdoOut(u_acso_if.sdoOut), .sdoOe(u_acso_if.sdoOe),
    .sckDevOe(u_acso_if.sckDevOe), .sckPullUp(u_acso_if.sckPullUp),
    .sckHostOe(u_acso_if.sckHostOe), .sckWire(u_acso_if.sckWire));
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  // word layout: done flag, dummy, sign, result, sub bits
  function automatic logic [WORD_BITS-1:0] mk_word(input logic s,
      input logic [RESULT_BITS-1:0] r, input logic [SUB_BITS-1:0] b);
    return {1'b0, DUMMY_VAL, s, r, b};
  endfunction
  // print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one read; a cut is raised abortAt cycles in (negative: none)
  task automatic do_read(input int abortAt);
    int n;
    @(negedge clk_sys) readReq = 1'b1;
    @(negedge clk_sys) readReq = 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk_sys);
      if (n == abortAt) abortReq = 1'b1;
      if (wordValid === 1'b1) break;
      if (abortAt >= 0 && n > abortAt + 20) break;
    end
    if (abortAt < 0) begin
      `CHK(wordData, expWord)
      `CHK(extMode, useExtSck)
    end else begin
      `CHK(wordValid, 1'b0)
      `CHK(readBusy, 1'b0)
      abortReq = 1'b0;
    end
    repeat (10) @(negedge clk_sys);
    `CHK(convBusy, 1'b1)
    `CHK(calActive, 1'b0)
  endtask
  // main sequence: random words with range corners, both clock modes
  initial begin
    logic [RESULT_BITS-1:0] r;
    logic s;
    logic [SUB_BITS-1:0] b;
    int i;
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    for (i = 0; i < 12; i++) begin
      r = RESULT_BITS'($random(seed));
      s = 1'($random(seed));
      b = SUB_BITS'($random(seed));
      if (i == 2) begin // overrange: sign and msb high
        r = '1;
        s = 1'b1;
      end
      if (i == 3) begin // underrange: sign and msb low
        r = '0;
        s = 1'b0;
      end
      resultIn = r;
      signIn = s;
      subIn = b;
      useExtSck = i[0];
      freqSel = (i < 6);
      expWord = mk_word(s, r, b);
      repeat (i == 6 ? 1250 : 150) @(negedge clk_sys);
      `CHK(notch50, freqSel)
      `CHK(extSysClk, 1'b0)
      resultIn = ~r; // asleep: held word must not follow inputs
      signIn = ~s;
      do_read(i == 5 ? 150 : -1);
    end
    // a toggling frequency pin is taken as the system clock
    repeat (520) begin
      repeat (4) @(negedge clk_sys);
      freqSel = ~freqSel;
    end
    `CHK(extSysClk, 1'b1)
    wrap_up();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
